// *** ird_regs.sv ***
// interrupt status/enable, tone result and indirect data port registers
`default_nettype none
module ird_regs
  import ird_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic       SDI,
  output logic            SDO,
  output logic            SDO_OE,
  input  wire logic [7:0] TIMER_EVT,
  input  wire logic [7:0] ALARM_EVT,
  input  wire logic       HOOK_STATE,
  input  wire logic       CAL_ACTIVE,
  input  wire logic       TONE_DETECT,
  input  wire logic [3:0] TONE_CODE,
  output logic            INT_N
);
  logic [6:0] addr;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  ird_spi_port u_spi (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .sclk_pin (SCLK),
    .cs_n_pin (CS_N),
    .sdi_pin  (SDI),
    .rd_data  (rd_data),
    .sdo      (SDO),
    .sdo_oe   (SDO_OE),
    .addr     (addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data)
  );

  logic [7:0]     pend1_r, pend2_r, mask1_r, mask2_r;
  logic [P3_W-1:0] pend3_r, mask3_r;
  logic [7:0]     data_r, addr_port_r;
  logic           busy_r, data_wr_r, hook_d_r, tone_d_r;
  logic [10:0]    tick_cnt_r;
  logic [10:0]    busy_age_r;
  logic [7:0]     mem [0:255];

  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire w_p1 = wr_stb & hit(addr, OFS_PEND_ONE);
  wire w_p2 = wr_stb & hit(addr, OFS_PEND_TWO);
  wire w_p3 = wr_stb & hit(addr, OFS_PEND_THREE);
  wire w_m1 = wr_stb & hit(addr, OFS_MASK_ONE);
  wire w_m2 = wr_stb & hit(addr, OFS_MASK_TWO);
  wire w_m3 = wr_stb & hit(addr, OFS_MASK_THREE);
  wire w_dl = wr_stb & hit(addr, OFS_DATA_LOW);
  wire w_ap = wr_stb & hit(addr, OFS_ADDR_PORT);

  wire tick = (tick_cnt_r == UPD_LAST);
  wire serv = tick & busy_r & ~w_ap;

  // event sources for status three
  wire cal_err_evt = CAL_ACTIVE & (HOOK_STATE ^ hook_d_r);
  wire tone_evt    = TONE_DETECT & ~tone_d_r;
  logic [P3_W-1:0] set3;
  assign set3[BIT_CAL_ERR]  = cal_err_evt;
  assign set3[BIT_IND_DONE] = serv;
  assign set3[BIT_TONE_KEY] = tone_evt;

  // a set in the same cycle as a clearing write wins
  wire [7:0] clr1 = w_p1 ? wr_data : RST_BYTE;
  wire [7:0] clr2 = w_p2 ? wr_data : RST_BYTE;
  wire [P3_W-1:0] clr3 = w_p3 ? wr_data[P3_W-1:0] : RST_P3;
  wire [7:0] pend1_nxt = (pend1_r & ~clr1) | TIMER_EVT;
  wire [7:0] pend2_nxt = (pend2_r & ~clr2) | ALARM_EVT;
  wire [P3_W-1:0] pend3_nxt = (pend3_r & ~clr3) | set3;

  // mask bits line up with pending bits position for position
  wire irq_any = |(pend1_r & mask1_r) | |(pend2_r & mask2_r)
               | |(pend3_r & mask3_r);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend1_r <= RST_BYTE;
      pend2_r <= RST_BYTE;
      pend3_r <= RST_P3;
      mask1_r <= RST_BYTE;
      mask2_r <= RST_BYTE;
      mask3_r <= RST_P3;
      INT_N   <= 1'b1;
    end else begin
      pend1_r <= pend1_nxt;
      pend2_r <= pend2_nxt;
      pend3_r <= pend3_nxt;
      if (w_m1) mask1_r <= wr_data;
      if (w_m2) mask2_r <= wr_data;
      if (w_m3) mask3_r <= wr_data[P3_W-1:0];
      INT_N   <= ~irq_any;
    end
  end

  // hook and tone levels come from on-chip logic on this clock
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hook_d_r <= 1'b0;
      tone_d_r <= 1'b0;
    end else begin
      hook_d_r <= HOOK_STATE;
      tone_d_r <= TONE_DETECT;
    end
  end

  // free-running update tick; the 16 kHz grid is shared by all requests
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) tick_cnt_r <= 11'h000;
    else          tick_cnt_r <= tick ? 11'h000 : tick_cnt_r + 11'h001;
  end

  // age of an outstanding request; a deferred one waits a whole period
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) busy_age_r <= 11'h000;
    else if (busy_r && !w_ap) busy_age_r <= busy_age_r + 11'h001;
    else busy_age_r <= 11'h000;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      data_r      <= RST_BYTE;
      addr_port_r <= RST_BYTE;
      busy_r      <= 1'b0;
      data_wr_r   <= 1'b0;
    end else begin
      if (w_ap) begin
        addr_port_r <= wr_data;
        busy_r      <= 1'b1;
      end else if (serv) begin
        busy_r      <= 1'b0;
        data_wr_r   <= 1'b0;
        if (!data_wr_r) data_r <= mem[addr_port_r];
      end
      if (w_dl) begin
        data_r    <= wr_data;
        data_wr_r <= 1'b1;
      end
    end
  end

  // memory holds no reset; contents are only defined once written
  always_ff @(posedge CLK) begin
    if (serv && data_wr_r && !w_ap) mem[addr_port_r] <= data_r;
  end

  wire [7:0] key_result = {3'h0, TONE_DETECT, TONE_CODE};

  assign rd_data =
      hit(addr, OFS_PEND_ONE)    ? pend1_r :
      hit(addr, OFS_PEND_TWO)    ? pend2_r :
      hit(addr, OFS_PEND_THREE)  ? {5'h00, pend3_r} :
      hit(addr, OFS_MASK_ONE)    ? mask1_r :
      hit(addr, OFS_MASK_TWO)    ? mask2_r :
      hit(addr, OFS_MASK_THREE)  ? {5'h00, mask3_r} :
      hit(addr, OFS_KEY_RESULT)  ? key_result :
      hit(addr, OFS_DATA_LOW)    ? data_r :
      hit(addr, OFS_ADDR_PORT)   ? addr_port_r :
      hit(addr, OFS_BUSY_STATUS) ? {7'h00, busy_r} : RST_BYTE;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_stored;
    (serv && data_wr_r) ##1 (mem[$past(addr_port_r)] == $past(data_r));
  endsequence

  sequence s_serviced;
    serv ##1 (!busy_r && pend3_r[BIT_IND_DONE]);
  endsequence

  AST_CAL_SET: assert property (
    cal_err_evt |=> pend3_r[BIT_CAL_ERR])
    else $error("calibration error not flagged");
  AST_W1C: assert property (
    (w_p3 && wr_data[BIT_CAL_ERR] && !cal_err_evt) |=> !pend3_r[BIT_CAL_ERR])
    else $error("pending flag not cleared by one");
  AST_HOLD: assert property (
    (pend2_r[0] && !(w_p2 && wr_data[0])) |=> pend2_r[0])
    else $error("pending flag lost without clear");
  AST_DONE: assert property (
    (busy_r && !w_ap && tick) |-> s_serviced)
    else $error("indirect service not reported");
  AST_BUSY_WAIT: assert property (
    w_ap |=> busy_r)
    else $error("indirect access not marked busy");
  AST_BUSY_AGE: assert property (
    busy_r |-> (busy_age_r <= UPD_LAST))
    else $error("indirect access never completed");
  AST_IRQ: assert property (
    (|(pend3_r & mask3_r)) |=> !INT_N)
    else $error("enabled pending flag not raising interrupt");
  AST_MASKED: assert property (
    (pend1_r == 8'h00 && pend2_r == 8'h00 && (pend3_r & mask3_r) == 3'h0)
      |=> INT_N)
    else $error("interrupt active with nothing enabled pending");
  AST_KEY: assert property (
    hit(addr, OFS_KEY_RESULT) |-> rd_data[BIT_TONE_DETECT] == TONE_DETECT)
    else $error("key valid flag misreported");
  AST_WRITE: assert property (
    (serv && data_wr_r) |-> s_stored)
    else $error("indirect write not stored");
  AST_TONE_SET: assert property (
    tone_evt |=> pend3_r[BIT_TONE_KEY])
    else $error("key detection not flagged");
  AST_MASK3_RD: assert property (
    hit(addr, OFS_MASK_THREE) |-> (rd_data[7:P3_W] == 5'h00))
    else $error("enable three upper bits not zero");
  AST_READ_LOAD: assert property (
    (serv && !data_wr_r && !w_dl) |=> (data_r == mem[$past(addr_port_r)]))
    else $error("indirect read not loaded into data port");
  AST_P1_SET: assert property (
    (TIMER_EVT != 8'h00) |=> ((pend1_r & $past(TIMER_EVT)) == $past(TIMER_EVT)))
    else $error("timer event not flagged");
endmodule : ird_regs
`default_nettype wire

// *** ird_pkg.sv ***
// constants for the interrupt, tone-result and indirect-access register slice
// Function
// - A hook change during calibration sets status three bit 2.
// - A pending flag holds until a one is written to it; zero keeps it.
// - Finishing an indirect read or write sets status three bit 1.
// - Pending flags read 1 when pending; status three bit 0 marks a key.
// - An enable bit of 0 masks its event; 1 lets it raise the interrupt.
// - Enable one masks the metering, ringing and two oscillator timers.
// - Enable two masks six power alarms, loop closure and ring trip.
// - Enable three masks calibration, indirect-done and key; 7..3 read 0.
// - Decoder status bit 4 reads 1 while a valid key is being detected.
// - Decoder status bits 3..0 carry the decoded key code.
// - Data write then address write stores the data at the next tick.
// - An address write alone reloads the data port at the next tick.
// - The busy flag reads 1 while an indirect access is outstanding.
// - Status one and two lay out their pending flags like the enables.
`default_nettype none
package ird_pkg;
  localparam logic [6:0] OFS_PEND_ONE    = 7'h12;
  localparam logic [6:0] OFS_PEND_TWO    = 7'h13;
  localparam logic [6:0] OFS_PEND_THREE  = 7'h14;
  localparam logic [6:0] OFS_MASK_ONE    = 7'h15;
  localparam logic [6:0] OFS_MASK_TWO    = 7'h16;
  localparam logic [6:0] OFS_MASK_THREE  = 7'h17;
  localparam logic [6:0] OFS_KEY_RESULT  = 7'h18;
  localparam logic [6:0] OFS_DATA_LOW    = 7'h1c;
  localparam logic [6:0] OFS_ADDR_PORT   = 7'h1e;
  localparam logic [6:0] OFS_BUSY_STATUS = 7'h1f;

  localparam int         BIT_TONE_KEY    = 0;
  localparam int         BIT_IND_DONE    = 1;
  localparam int         BIT_CAL_ERR     = 2;
  localparam int         BIT_TONE_DETECT = 4;
  localparam int         P3_W            = 3;

  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [2:0] RST_P3          = 3'h0;

  localparam int         CMD_RD_BIT      = 7;
  localparam logic [4:0] BITS_CMD        = 5'h08;
  localparam logic [4:0] BITS_FRAME      = 5'h10;

  localparam int         CLK_HZ          = 20000000;
  localparam int         UPD_RATE_HZ     = 16000;
  localparam int         UPD_CYC         = CLK_HZ / UPD_RATE_HZ;
  localparam logic [10:0] UPD_LAST       = 11'(UPD_CYC - 1);

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_CMD  = 2'b01,
    SPI_DATA = 2'b11
  } ird_spi_state_t;
endpackage : ird_pkg
`default_nettype wire

// *** ird_spi_port.sv ***
// serial control port: command byte then data byte, msb first
`default_nettype none
module ird_spi_port
  import ird_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       sclk_pin,
  input  wire logic       cs_n_pin,
  input  wire logic       sdi_pin,
  input  wire logic [7:0] rd_data,
  output logic            sdo,
  output logic            sdo_oe,
  output logic [6:0]      addr,
  output logic            wr_stb,
  output logic [7:0]      wr_data
);
  logic [2:0]     s1_r, s2_r;
  logic           sclk_d_r;
  ird_spi_state_t st_r, st_nxt;
  logic [4:0]     cnt_r;
  logic [7:0]     sh_r, cmd_r, tx_r;
  logic           wr_stb_r;
  logic [7:0]     wr_data_r;

  // two flops on every pin; the second stage is looked at, and sclk gets a third flop for edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r     <= 3'h2;
      s2_r     <= 3'h2;
      sclk_d_r <= 1'b0;
    end else begin
      s1_r     <= {sclk_pin, cs_n_pin, sdi_pin};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[2];
    end
  end

  wire       sclk_s = s2_r[2];
  wire       cs_s   = ~s2_r[1];
  wire       sdi_s  = s2_r[0];
  wire       rise   = cs_s & sclk_s & ~sclk_d_r;
  wire       fall   = cs_s & ~sclk_s & sclk_d_r;
  wire [4:0] cnt_up = cnt_r + 5'h01;
  wire [7:0] sh_in  = {sh_r[6:0], sdi_s};
  wire       is_rd  = cmd_r[CMD_RD_BIT];

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SPI_IDLE: if (cs_s) st_nxt = SPI_CMD;
      SPI_CMD:  if (!cs_s) st_nxt = SPI_IDLE;
                else if (rise && cnt_up == BITS_CMD) st_nxt = SPI_DATA;
      SPI_DATA: if (!cs_s) st_nxt = SPI_IDLE;
      default:  st_nxt = SPI_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r      <= SPI_IDLE;
      cnt_r     <= 5'h00;
      sh_r      <= RST_BYTE;
      cmd_r     <= RST_BYTE;
      tx_r      <= RST_BYTE;
      wr_stb_r  <= 1'b0;
      wr_data_r <= RST_BYTE;
    end else begin
      st_r     <= st_nxt;
      wr_stb_r <= 1'b0;
      if (!cs_s) begin
        cnt_r <= 5'h00;
      end else if (rise) begin
        cnt_r <= cnt_up;
        sh_r  <= sh_in;
        if (cnt_up == BITS_CMD) cmd_r <= sh_in;
        if (cnt_up == BITS_FRAME && !is_rd) begin
          wr_stb_r  <= 1'b1;
          wr_data_r <= sh_in;
        end
      end
      // read data is taken on the falling edge after the command byte
      if (fall && st_r == SPI_DATA) begin
        tx_r <= (cnt_r == BITS_CMD) ? rd_data : {tx_r[6:0], 1'b0};
      end
    end
  end

  assign addr    = cmd_r[6:0];
  assign wr_stb  = wr_stb_r;
  assign wr_data = wr_data_r;
  assign sdo     = tx_r[7];
  assign sdo_oe  = cs_s & (st_r == SPI_DATA) & is_rd;
endmodule : ird_spi_port
`default_nettype wire

// *** ird_host_model.sv ***
// host processor model driving frames on the serial control port
`default_nettype none
module ird_host_model (
  input  wire logic clk,
  input  wire logic sdo,
  output var logic  sclk,
  output var logic  cs_n,
  output var logic  sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  // six cycles a phase covers the port's synchroniser and sdo latency
  localparam int HALF = 6;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] frm;
    frm = {cmd, wd};
    rd = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi <= frm[i];
      repeat (HALF) @(posedge clk);
      sclk <= 1'b1;
      if (i < 8) rd[i] = sdo;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    // released line shows the inverse so a stale bit is never trusted
    sdi <= ~sdi;
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : ird_host_model
`default_nettype wire

// *** test_irq_dual_tone_keypad_indirect_regs.sv ***
// self-checking bench for the interrupt, key-result and indirect-port slice
`default_nettype none
module test_irq_dual_tone_keypad_indirect_regs
  import ird_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] timer_evt = 8'h00;
  logic [7:0] alarm_evt = 8'h00;
  logic       hook = 1'b0;
  logic       cal = 1'b0;
  logic       det = 1'b0;
  logic [3:0] code = 4'h0;
  int         error_cnt = 0;
  int         check_count = 0;
  wire logic  sclk;
  wire logic  cs_n;
  wire logic  sdi;
  wire logic  sdo;
  wire logic  int_n;
  wire logic  sdo_oe;
  wire logic  host_sdo;

  always #25 clk = ~clk;

  // an undriven line reads inverted, so a read outside the enable fails
  assign host_sdo = sdo_oe ? sdo : ~sdo;

  ird_host_model host (.clk(clk), .sdo(host_sdo), .sclk(sclk), .cs_n(cs_n),
                       .sdi(sdi));
  ird_regs dut (.CLK(clk), .RESET_N(reset_n), .SCLK(sclk), .CS_N(cs_n),
    .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .TIMER_EVT(timer_evt),
    .ALARM_EVT(alarm_evt), .HOOK_STATE(hook), .CAL_ACTIVE(cal),
    .TONE_DETECT(det), .TONE_CODE(code), .INT_N(int_n));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer({1'b0, ofs}, d, unused);
  endtask : wr

  task automatic rc(input logic [6:0] ofs, input logic [7:0] exp);
    logic [7:0] got;
    host.xfer({1'b1, ofs}, 8'h00, got);
    chk(got, exp);
  endtask : rc

  task automatic irq(input logic exp);
    repeat (3) @(posedge clk);
    chk({7'h00, int_n}, {7'h00, exp});
  endtask : irq

  // bounded wait for the update tick, seen through the enabled done flag
  task automatic wait_tick;
    int n;
    n = 0;
    while (int_n !== 1'b0 && n < 1400) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, int_n}, 8'h00);
  endtask : wait_tick

  task automatic t_reset;
    rc(OFS_PEND_THREE, 8'h00);
    rc(OFS_MASK_ONE, 8'h00);
    rc(OFS_MASK_TWO, 8'h00);
    rc(OFS_MASK_THREE, 8'h00);
    rc(OFS_DATA_LOW, 8'h00);
    rc(7'h20, 8'h00);
    irq(1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_masks;
    wr(OFS_MASK_ONE, 8'ha5);
    rc(OFS_MASK_ONE, 8'ha5);
    wr(OFS_MASK_TWO, 8'h5a);
    rc(OFS_MASK_TWO, 8'h5a);
    wr(OFS_MASK_THREE, 8'hff);
    rc(OFS_MASK_THREE, 8'h07);
    wr(OFS_MASK_ONE, 8'h00);
    wr(OFS_MASK_TWO, 8'h00);
    wr(OFS_MASK_THREE, 8'h00);
    $display("test masks done");
  endtask : t_masks

  task automatic t_events;
    @(posedge clk);
    timer_evt <= 8'h81;
    alarm_evt <= 8'h43;
    @(posedge clk);
    timer_evt <= 8'h00;
    alarm_evt <= 8'h00;
    irq(1'b1);
    rc(OFS_PEND_ONE, 8'h81);
    rc(OFS_PEND_TWO, 8'h43);
    wr(OFS_MASK_ONE, 8'h80);
    irq(1'b0);
    wr(OFS_PEND_ONE, 8'h80);
    rc(OFS_PEND_ONE, 8'h01);
    irq(1'b1);
    wr(OFS_MASK_TWO, 8'h02);
    irq(1'b0);
    wr(OFS_PEND_TWO, 8'hff);
    rc(OFS_PEND_TWO, 8'h00);
    irq(1'b1);
    wr(OFS_MASK_ONE, 8'h00);
    wr(OFS_MASK_TWO, 8'h00);
    $display("test events done");
  endtask : t_events

  task automatic t_cal;
    @(posedge clk);
    hook <= 1'b1;
    rc(OFS_PEND_THREE, 8'h00);
    cal <= 1'b1;
    hook <= 1'b0;
    rc(OFS_PEND_THREE, 8'h04);
    wr(OFS_PEND_THREE, 8'h00);
    rc(OFS_PEND_THREE, 8'h04);
    wr(OFS_MASK_THREE, 8'h04);
    irq(1'b0);
    wr(OFS_PEND_THREE, 8'h04);
    rc(OFS_PEND_THREE, 8'h00);
    irq(1'b1);
    cal <= 1'b0;
    $display("test calibration done");
  endtask : t_cal

  task automatic t_key;
    @(posedge clk);
    det <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      code <= 4'(c);
      rc(OFS_KEY_RESULT, {4'h1, 4'(c)});
    end
    rc(OFS_PEND_THREE, 8'h01);
    wr(OFS_KEY_RESULT, 8'h00);
    det <= 1'b0;
    rc(OFS_KEY_RESULT, 8'h0f);
    wr(OFS_PEND_THREE, 8'h01);
    rc(OFS_PEND_THREE, 8'h00);
    $display("test key done");
  endtask : t_key

  task automatic t_indirect;
    wr(OFS_MASK_THREE, 8'h02);
    wr(OFS_DATA_LOW, 8'h3c);
    wr(OFS_ADDR_PORT, 8'h21);
    wait_tick();
    wr(OFS_PEND_THREE, 8'h02);
    wr(OFS_DATA_LOW, 8'hc3);
    wr(OFS_ADDR_PORT, 8'h22);
    wait_tick();
    rc(OFS_PEND_THREE, 8'h02);
    wr(OFS_PEND_THREE, 8'h02);
    // right after a tick, so the next one is still far away
    wr(OFS_ADDR_PORT, 8'h21);
    rc(OFS_BUSY_STATUS, 8'h01);
    wait_tick();
    rc(OFS_DATA_LOW, 8'h3c);
    rc(OFS_BUSY_STATUS, 8'h00);
    $display("test indirect done");
  endtask : t_indirect

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_masks();
    t_events();
    t_cal();
    t_key();
    t_indirect();
    end_sim();
  end

  initial begin
    // the tests need about 15500 cycles; the 40000-cycle limit is over twice that
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule : test_irq_dual_tone_keypad_indirect_regs
`default_nettype wire
